/* logic/vpep_pkg.sv */
// Purpose: Constants and types for the emulated link partner block
// Assumes: One system clock, synchronous active-low chip reset
// Notes: Registers are 32-bit words, upper half reads zero
//
// Notes on behaviour
// RULE_01 - Registers are 32 bits, upper 16 reserved zero; serial access sees 16 bits.
// RULE_02 - Partner reports no next page, acknowledge set, no remote fault, no T4.
// RULE_03 - Partner pause bits mirror local advertisement per the pause table.
// RULE_04 - Both local pause bits set: preference strap picks symmetric or asymmetric.
// RULE_05 - Partner pause bits latched only at negotiation completion.
// RULE_06 - Straps sampled and held when chip reset is released.
// RULE_07 - Duplex pin versus polarity strap and speed strap pick ability bits 8..5.
// RULE_08 - Speed and duplex ability also depend on negotiation success.
// RULE_09 - Parallel detection fault bit 4 always reads zero.
// RULE_10 - Next-page-able bits 3 and 2 always read zero.
// RULE_11 - Page received clears on reset, sets after negotiation, clears on read.
// RULE_12 - Partner-negotiation-able bit reads one unless no common ability exists.
// RULE_13 - Expansion register at byte offset 1d8, management index 6.
// RULE_14 - Partner selector reads 00001; partner ability register is read-only.
// RULE_15 - All partner ability outputs update together on the completion cycle; lp_ability_reg and an_expansion_reg change one clock after partner_q.
package vpep_pkg;
	localparam logic [8:0] OFS_LP_ABILITY = 9'h1d4;
	localparam logic [8:0] OFS_EXPANSION = 9'h1d8;
	localparam logic [4:0] IDX_LP_ABILITY = 5'h05;
	localparam logic [4:0] IDX_EXPANSION = 5'h06;
	localparam logic [4:0] SELECTOR_8023 = 5'h01;
	localparam logic [3:0] ABIL_10_FD = 4'h2;
	localparam logic [3:0] ABIL_100_FD = 4'h8;
	localparam logic [3:0] ABIL_10_HD = 4'h1;
	localparam logic [3:0] ABIL_100_HD = 4'h4;
	localparam logic [3:0] ABIL_RESET = 4'h0;
	localparam logic PAGE_RX_RESET = 1'b0;
	localparam logic AN_ABLE_RESET = 1'b1;
	// Images keep their fixed bits through reset so no check sees a gap
	localparam logic [15:0] LP_IMG_RESET = 16'h4001;
	localparam logic [15:0] EXP_IMG_RESET = 16'h0001;

	typedef struct packed {
		logic asym;
		logic sym;
		logic [3:0] abil;
	} vpep_partner_type;

	typedef struct packed {
		logic flowctl_pref;
		logic duplex_pol;
		logic speed;
	} vpep_strap_type;
endpackage

/* logic/vpep_partner.sv */
// Purpose: Emulated link partner of the virtual PHY during auto-negotiation
// Assumes: an_done pulses one cycle when negotiation completes
// Notes: Reads addressed by byte offset or by management index
`timescale 1ns/1ps
`default_nettype none
module vpep_partner (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Pins and straps
	input wire logic port0_duplex_pin,
	input wire logic fullduplex_flowctl_pref_strap,
	input wire logic duplex_pol_strap,
	input wire logic speed_strap,
	// Local advertisement and negotiation events
	input wire logic [3:0] local_abil,
	input wire logic local_sym_pause,
	input wire logic local_asym_pause,
	input wire logic an_done,
	// Register read port
	input wire logic rd_en,
	input wire logic rd_serial,
	input wire logic [8:0] rd_addr,
	input wire logic [4:0] rd_index,
	output logic [31:0] rd_data,
	output logic rd_valid,
	// Partner state
	output logic [15:0] lp_ability_reg,
	output logic [15:0] an_expansion_reg
);
	// ****************************************
	// Pin synchronisers and straps
	// ****************************************
	logic [1:0] dup_sync_q, dup_sync_d;
	logic nrst_seen_q, nrst_seen_d;
	vpep_pkg::vpep_strap_type strap_q, strap_d;
	// Straps are pins too; two stages keep a slow edge at release harmless
	vpep_pkg::vpep_strap_type strap_meta_q, strap_meta_d;
	vpep_pkg::vpep_strap_type strap_sync_q, strap_sync_d;

	always_comb begin
		dup_sync_d = {dup_sync_q[0], port0_duplex_pin};
		strap_meta_d = '{flowctl_pref: fullduplex_flowctl_pref_strap,
			duplex_pol: duplex_pol_strap, speed: speed_strap};
		strap_sync_d = strap_meta_q;
		nrst_seen_d = 1'b1;
		strap_d = strap_q;
		// First clock after release latches, later changes ignored
		if (!nrst_seen_q) begin
			strap_d = strap_sync_q; // RULE_06
		end
	end

	always_ff @(posedge clk_sys) begin
		dup_sync_q <= dup_sync_d;
		strap_meta_q <= strap_meta_d;
		strap_sync_q <= strap_sync_d;
		if (!nrst) begin
			nrst_seen_q <= 1'b0;
			strap_q <= '0;
		end else begin
			nrst_seen_q <= nrst_seen_d;
			strap_q <= strap_d;
		end
	end

	// ****************************************
	// Partner ability computation
	// ****************************************
	function automatic vpep_pkg::vpep_partner_type calc_partner(
		input logic sym, input logic asym, input vpep_pkg::vpep_strap_type s,
		input logic dup, input logic [3:0] local_a);
		vpep_pkg::vpep_partner_type p;
		logic fd;
		p = '0;
		fd = (dup == s.duplex_pol); // RULE_07
		case ({sym, asym})
			2'b00: begin p.sym = 1'b0; p.asym = 1'b0; end // RULE_03
			2'b10: begin p.sym = 1'b1; p.asym = 1'b0; end // RULE_03
			2'b01: begin p.sym = 1'b1; p.asym = 1'b1; end // RULE_03
			default: begin
				p.sym = s.flowctl_pref; // RULE_04
				p.asym = 1'b1; // RULE_04
			end
		endcase
		if (s.speed) begin
			p.abil = fd ? vpep_pkg::ABIL_100_FD : vpep_pkg::ABIL_100_HD;
		end else begin
			p.abil = fd ? vpep_pkg::ABIL_10_FD : vpep_pkg::ABIL_10_HD;
		end
		// Failed negotiation leaves no shared ability to report
		if ((p.abil & local_a) == 4'h0) begin
			p.abil = vpep_pkg::ABIL_RESET; // RULE_08
		end
		return p;
	endfunction

	vpep_pkg::vpep_partner_type partner_q, partner_d, partner_c;
	logic page_rx_q, page_rx_d;
	logic an_able_q, an_able_d;
	logic exp_hit, lp_hit;

	always_comb begin
		partner_c = calc_partner(local_sym_pause, local_asym_pause, strap_q,
			dup_sync_q[1], local_abil);
		partner_d = partner_q;
		an_able_d = an_able_q;
		page_rx_d = page_rx_q;
		// Hit decode shared by clear-on-read and the data mux
		exp_hit = rd_serial ? (rd_index == vpep_pkg::IDX_EXPANSION)
			: (rd_addr == vpep_pkg::OFS_EXPANSION); // RULE_13
		lp_hit = rd_serial ? (rd_index == vpep_pkg::IDX_LP_ABILITY)
			: (rd_addr == vpep_pkg::OFS_LP_ABILITY);
		if (rd_en && exp_hit) begin
			page_rx_d = 1'b0; // RULE_11
		end
		if (an_done) begin
			partner_d = partner_c; // RULE_05 RULE_15
			an_able_d = (partner_c.abil != 4'h0); // RULE_12
			page_rx_d = 1'b1; // RULE_11
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			partner_q <= '0;
			page_rx_q <= vpep_pkg::PAGE_RX_RESET;
			an_able_q <= vpep_pkg::AN_ABLE_RESET;
		end else begin
			partner_q <= partner_d;
			page_rx_q <= page_rx_d;
			an_able_q <= an_able_d;
		end
	end

	// ****************************************
	// Register images and read port
	// ****************************************
	logic [15:0] lp_img, exp_img;
	logic [31:0] rd_data_d;
	logic [15:0] lp_reg_q, exp_reg_q;
	logic [31:0] rd_data_q;
	logic rd_valid_q;

	always_comb begin
		// Bit 15 no next page, 14 ack, 13 fault, 12 rsvd, 9 T4
		lp_img = {1'b0, 1'b1, 1'b0, 1'b0, partner_q.asym, partner_q.sym,
			1'b0, partner_q.abil, vpep_pkg::SELECTOR_8023}; // RULE_02 RULE_14
		exp_img = {11'h000, 1'b0, 2'b00, page_rx_q, an_able_q}; // RULE_09 RULE_10
		rd_data_d = 32'h0000_0000; // RULE_01
		if (rd_en && exp_hit) begin
			rd_data_d[15:0] = exp_img;
		end else if (rd_en && lp_hit) begin
			rd_data_d[15:0] = lp_img;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rd_data_q <= 32'h0000_0000;
			rd_valid_q <= 1'b0;
			lp_reg_q <= vpep_pkg::LP_IMG_RESET;
			exp_reg_q <= vpep_pkg::EXP_IMG_RESET;
		end else begin
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_en;
			lp_reg_q <= lp_img;
			exp_reg_q <= exp_img;
		end
	end

	assign rd_data = rd_data_q;
	assign rd_valid = rd_valid_q;
	assign lp_ability_reg = lp_reg_q;
	assign an_expansion_reg = exp_reg_q;

	// ****************************************
	// Checks
	// ****************************************
	a_exp_fixed_zero: assert property (@(posedge clk_sys) // RULE_09
		disable iff (!nrst)
		an_expansion_reg[4:2] == 3'b000)
		else $error("fixed bits nonzero");
	a_upper_zero: assert property (@(posedge clk_sys) // RULE_01
		disable iff (!nrst)
		rd_data[31:16] == 16'h0000)
		else $error("upper half nonzero");
	a_page_set: assert property (@(posedge clk_sys) // RULE_11
		disable iff (!nrst)
		an_done |=> page_rx_q)
		else $error("page received not set");
	a_page_clear: assert property (@(posedge clk_sys) // RULE_11
		disable iff (!nrst)
		rd_en && exp_hit && !an_done |=> !page_rx_q)
		else $error("no read clear");
	a_pause_hold: assert property (@(posedge clk_sys) // RULE_05
		disable iff (!nrst)
		!an_done |=> $stable(partner_q))
		else $error("partner changed early");
	a_pause_calc: assert property (@(posedge clk_sys) // RULE_04
		disable iff (!nrst)
		an_done && local_sym_pause && local_asym_pause |=>
		partner_q.asym && partner_q.sym == strap_q.flowctl_pref)
		else $error("pause preference wrong");
	a_able_fail: assert property (@(posedge clk_sys) // RULE_12
		disable iff (!nrst)
		an_done |=> an_able_q == (partner_q.abil != 4'h0))
		else $error("able wrong");
	a_lp_fixed: assert property (@(posedge clk_sys) // RULE_14
		disable iff (!nrst)
		lp_ability_reg[15:12] == 4'h4 && lp_ability_reg[4:0] == 5'h01)
		else $error("fixed partner bits wrong");
	a_strap_hold: assert property (@(posedge clk_sys) // RULE_06
		disable iff (!nrst)
		nrst_seen_q |=> $stable(strap_q))
		else $error("strap changed");
	// Each pause row stands apart so a wrong row is named on its own
	a_pause_none: assert property (@(posedge clk_sys) // RULE_03
		disable iff (!nrst)
		an_done && !local_sym_pause && !local_asym_pause |=>
		!partner_q.sym && !partner_q.asym)
		else $error("pause none row wrong");
	a_pause_sym: assert property (@(posedge clk_sys) // RULE_03
		disable iff (!nrst)
		an_done && local_sym_pause && !local_asym_pause |=>
		partner_q.sym && !partner_q.asym)
		else $error("pause symmetric row wrong");
	a_pause_asym: assert property (@(posedge clk_sys) // RULE_03
		disable iff (!nrst)
		an_done && !local_sym_pause && local_asym_pause |=>
		partner_q.sym && partner_q.asym)
		else $error("pause asymmetric row wrong");
	a_abil_onehot: assert property (@(posedge clk_sys) // RULE_07
		disable iff (!nrst)
		$onehot0(partner_q.abil))
		else $error("more than one ability bit");
	a_next_page_zero: assert property (@(posedge clk_sys) // RULE_10
		disable iff (!nrst)
		an_expansion_reg[3:2] == 2'b00)
		else $error("next page bits nonzero");
	a_lp_top_bits: assert property (@(posedge clk_sys) // RULE_02
		disable iff (!nrst)
		lp_ability_reg[15:13] == 3'b010 && !lp_ability_reg[9])
		else $error("partner top bits wrong");
	a_read_valid: assert property (@(posedge clk_sys) // RULE_13
		disable iff (!nrst)
		rd_en |=> rd_valid)
		else $error("read not answered");
	a_exp_decode: assert property (@(posedge clk_sys) // RULE_13
		disable iff (!nrst)
		rd_en && rd_serial && rd_index == vpep_pkg::IDX_EXPANSION |=>
		rd_data[15:0] == an_expansion_reg)
		else $error("expansion index decode wrong");
	a_rd_idle: assert property (@(posedge clk_sys) // RULE_01
		disable iff (!nrst)
		!rd_en |=> rd_data == 32'h0000_0000)
		else $error("data without read");
	a_able_hold: assert property (@(posedge clk_sys) // RULE_12
		disable iff (!nrst)
		!an_done |=> $stable(an_able_q))
		else $error("able changed early");
endmodule
`default_nettype wire

/* tb/vpep_host.sv */
// Purpose: Management host model doing register reads
// Assumes: Answer arrives one cycle after the strobe
// Notes: Address inverted when idle so stale decode shows
`timescale 1ns/1ps
`default_nettype none
module vpep_host (
	// Clock
	input wire logic clk_sys,
	// Request
	output logic rd_en,
	output logic rd_serial,
	output logic [8:0] rd_addr,
	output logic [4:0] rd_index,
	// Answer
	input wire logic [31:0] rd_data,
	input wire logic rd_valid
);
	initial begin
		rd_en = 1'b0;
		rd_serial = 1'b0;
		rd_addr = 9'h000;
		rd_index = 5'h00;
	end
	// ***
	// Read
	// ***
	task automatic rd(input logic s, input logic [8:0] a,
		output logic [31:0] d, output logic ok);
		int i;
		ok = 1'b0;
		d = 32'h0;
		@(posedge clk_sys);
		rd_en <= 1'b1;
		rd_serial <= s;
		rd_addr <= a;
		rd_index <= a[4:0];
		@(posedge clk_sys);
		rd_en <= 1'b0;
		rd_addr <= ~a;
		rd_index <= ~a[4:0];
		// Answer is registered, so it stands at the edge after the strobe
		for (i = 0; i < 3 && !ok; i++) begin
			@(posedge clk_sys);
			if (rd_valid === 1'b1) begin
				d = rd_data;
				ok = 1'b1;
			end
		end
	endtask
endmodule
`default_nettype wire

/* tb/vpep_partner_tb_top.sv */
// Purpose: Self-checking bench for the emulated partner
// Assumes: Reads through the host model
// Notes: Straps are changed after release to prove capture
`timescale 1ns/1ps
`default_nettype none
module vpep_partner_tb_top;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic dup = 1'b0, pref = 1'b1, pol = 1'b0, spd = 1'b1;
	logic lsym = 1'b1, lasym = 1'b1, an_done = 1'b0;
	logic [3:0] labil = 4'hf;
	logic rd_en, rd_serial, rd_valid, ok;
	logic [8:0] rd_addr;
	logic [4:0] rd_index;
	logic [31:0] rd_data, d;
	logic [15:0] lp_img_o, exp_img_o;
	logic [31:0] pexp [4] = '{32'h4101, 32'h4d01, 32'h4501, 32'h4d01};
	int mismatches = 0, tests_run = 0;
	always #10 clk_sys = ~clk_sys;
	vpep_partner vpep_partner_i (.clk_sys(clk_sys), .nrst(nrst),
		.port0_duplex_pin(dup), .fullduplex_flowctl_pref_strap(pref),
		.duplex_pol_strap(pol), .speed_strap(spd), .local_abil(labil),
		.local_sym_pause(lsym), .local_asym_pause(lasym),
		.an_done(an_done), .rd_en(rd_en), .rd_serial(rd_serial),
		.rd_addr(rd_addr), .rd_index(rd_index), .rd_data(rd_data),
		.rd_valid(rd_valid), .lp_ability_reg(lp_img_o),
		.an_expansion_reg(exp_img_o));
	vpep_host vpep_host_i (.clk_sys(clk_sys), .rd_en(rd_en),
		.rd_serial(rd_serial), .rd_addr(rd_addr), .rd_index(rd_index),
		.rd_data(rd_data), .rd_valid(rd_valid));
	// ***
	// Tasks
	// ***
	task automatic close_out;
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic s, input logic [8:0] a,
		input logic [31:0] exp);
		vpep_host_i.rd(s, a, d, ok);
		if (ok !== 1'b1) begin
			mismatches++;
			close_out();
		end else begin
			chk(d, exp);
		end
	endtask
	task automatic reset_dut;
		@(posedge clk_sys) nrst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic neg;
		@(posedge clk_sys) an_done <= 1'b1;
		@(posedge clk_sys) an_done <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	// ***
	// Sequence
	// ***
	initial begin
		reset_dut();
		@(negedge clk_sys);
		chk({16'h0000, lp_img_o}, 32'h4001);
		chk({16'h0000, exp_img_o}, 32'h1);
		rchk(1'b1, 9'h006, 32'h1);
		rchk(1'b0, 9'h100, 32'h0);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) {lsym, lasym} <= i[1:0];
			neg();
			rchk(1'b0, 9'h1d4, pexp[i]);
		end
		@(posedge clk_sys) {lsym, lasym} <= 2'b00;
		rchk(1'b1, 9'h005, 32'h4d01);
		rchk(1'b0, 9'h1d8, 32'h3);
		rchk(1'b0, 9'h1d8, 32'h1);
		@(posedge clk_sys) {pref, pol, spd, lsym, lasym} <= 5'b01011;
		reset_dut();
		@(posedge clk_sys) {pref, pol, spd} <= 3'b101;
		neg();
		rchk(1'b0, 9'h1d4, 32'h4821);
		@(posedge clk_sys) labil <= 4'h2;
		neg();
		rchk(1'b0, 9'h1d4, 32'h4801);
		rchk(1'b1, 9'h006, 32'h2);
		@(posedge clk_sys) {dup, labil} <= 5'h1f;
		repeat (3) @(posedge clk_sys);
		neg();
		rchk(1'b0, 9'h1d4, 32'h4841);
		// Read clear and completion on one edge: the set must win
		fork
			rchk(1'b0, 9'h1d8, 32'h3);
			neg();
		join
		rchk(1'b1, 9'h006, 32'h3);
		@(negedge clk_sys);
		chk({16'h0000, exp_img_o}, 32'h1);
		chk({16'h0000, lp_img_o}, 32'h4841);
		close_out();
	end
endmodule
`default_nettype wire
